// ==== rtl/vfss_pkg.sv ====
// Constants and types for the paired single-precision subtract and root unit.
// Assumes the core's issue logic and register file share this unit's clock.
package vfss_pkg;

   // ----------------------------------------------------------------
   // Special values
   // ----------------------------------------------------------------
   localparam logic [31:0] VFSS_PMAX = 32'h7f7f_ffff;
   localparam logic [31:0] VFSS_NMAX = 32'hff7f_ffff;
   localparam logic [31:0] VFSS_POS_ZERO = 32'h0000_0000;
   localparam logic [31:0] VFSS_NEG_ZERO = 32'h8000_0000;
   localparam logic [7:0] VFSS_EXP_MAX = 8'hff;
   localparam logic [8:0] VFSS_BIAS = 9'h07f;

   // ----------------------------------------------------------------
   // Timing counts and reset values
   // ----------------------------------------------------------------
   localparam logic [4:0] VFSS_SQRT_STEPS = 5'h19;
   localparam logic [7:0] VFSS_SHIFT_CAP = 8'h32;
   localparam logic [1:0] VFSS_RST_SYNC_RESET = 2'h0;

   // ----------------------------------------------------------------
   // Enumerations
   // ----------------------------------------------------------------
   typedef enum logic [2:0] {
      VFSS_OP_SQRT,
      VFSS_OP_SUB,
      VFSS_OP_SUBADD,
      VFSS_OP_SUBADDX,
      VFSS_OP_SUBX
   } vfss_op_e;

   typedef enum logic [1:0] {
      VFSS_ROUND_TO_NEAREST,
      VFSS_ROUND_TOWARD_ZERO,
      VFSS_ROUND_TOWARD_PLUS_INFINITY,
      VFSS_ROUND_TOWARD_MINUS_INFINITY
   } vfss_rnd_e;

   typedef enum logic [1:0] {VFSS_IDLE, VFSS_ROOT, VFSS_FINISH} vfss_fsm_e;

   // ----------------------------------------------------------------
   // Carriers
   // ----------------------------------------------------------------
   typedef struct packed {
      logic invalid;
      logic overflow;
      logic underflow;
      logic inexact;
   } vfss_en_s;

   typedef struct packed {
      logic invalid_flag_high;
      logic invalid_flag_low;
      logic overflow_flag_high;
      logic overflow_flag_low;
      logic underflow_flag_high;
      logic underflow_flag_low;
      logic guard_bit_high;
      logic guard_bit_low;
      logic sticky_bit_high;
      logic sticky_bit_low;
   } vfss_flags_s;

   typedef struct packed {
      logic [31:0] res;
      logic guard;
      logic sticky;
      logic ovf;
      logic unf;
      logic inv;
   } vfss_elem_s;

   typedef struct packed {
      logic [49:0] rad;
      logic [27:0] rem;
      logic [24:0] root;
   } vfss_root_s;

   typedef struct packed {
      vfss_fsm_e fsm;
      vfss_op_e op;
      vfss_rnd_e rnd;
      vfss_en_s en;
      logic [63:0] a;
      logic [63:0] b;
      logic [4:0] step;
      vfss_root_s rh;
      vfss_root_s rl;
      logic busy;
      logic done;
      logic dest_we;
      logic [63:0] dest;
      vfss_flags_s flags;
      logic inexact_sticky_low;
      logic inexact_sticky_high;
      logic irq_data;
      logic irq_round;
   } vfss_state_s;

endpackage

// ==== rtl/vfss_unit.sv ====
// Paired single-precision square root, subtract and exchanged subtract/add.
// Assumes operands and control come from logic on the same clock; one
// operation at a time, taken only while busy is low.
`timescale 1ns/1ps

module vfss_unit
   import vfss_pkg::*;
(
   input wire logic clk,
   input wire logic rst_b,
   input wire logic op_valid,
   input wire vfss_op_e op_code,
   input wire logic [63:0] src_a,
   input wire logic [63:0] src_b,
   input wire vfss_rnd_e round_mode,
   input wire vfss_en_s exc_enable,
   input wire logic sticky_clear,
   output logic busy,
   output logic done,
   output logic dest_we,
   output logic [63:0] dest_reg,
   output vfss_flags_s flags,
   output logic inexact_sticky_low,
   output logic inexact_sticky_high,
   output logic irq_data,
   output logic irq_round
);

   // ----------------------------------------------------------------
   // Element helpers
   // ----------------------------------------------------------------

   // Infinity, NaN or denormal
   function automatic logic is_bad(input logic [31:0] x);
      return (x[30:23] == VFSS_EXP_MAX) || (x[30:23] == 8'h00 && x[22:0] != 23'h0);
   endfunction

   // Odd exponents shift one less so the root lands with its lead at bit 24
   function automatic vfss_root_s root_load(input logic [31:0] x);
      vfss_root_s r;
      r.rem = '0;
      r.root = '0;
      if (x[23]) begin
         r.rad = {1'b0, 1'b1, x[22:0], 25'h0};
      end else begin
         r.rad = {1'b1, x[22:0], 26'h0};
      end
      return r;
   endfunction

   // One restoring step, two radicand bits per cycle
   function automatic vfss_root_s root_step(input vfss_root_s s);
      vfss_root_s r;
      logic [27:0] acc;
      logic [27:0] trial;
      acc = {s.rem[25:0], s.rad[49:48]};
      trial = {1'b0, s.root, 2'b01};
      r.rad = {s.rad[47:0], 2'b00};
      if (acc >= trial) begin
         r.rem = acc - trial;
         r.root = {s.root[23:0], 1'b1};
      end else begin
         r.rem = acc;
         r.root = {s.root[23:0], 1'b0};
      end
      return r;
   endfunction

   // Root result with special inputs; never overflows or underflows
   function automatic vfss_elem_s root_fin(input logic [31:0] x, input vfss_root_s s);
      vfss_elem_s r;
      logic [8:0] e;
      e = {1'b0, x[30:23]} + VFSS_BIAS;
      r = '0;
      if (x[30:23] == 8'h00) begin
         r.res = {x[31], 31'h0};
         r.inv = (x[22:0] != 23'h0);
      end else if (x[31]) begin
         r.res = VFSS_NEG_ZERO;
         r.inv = 1'b1;
      end else if (x[30:23] == VFSS_EXP_MAX) begin
         r.res = VFSS_PMAX;
         r.inv = 1'b1;
      end else begin
         r.res = {1'b0, e[8:1], s.root[23:1]};
         r.guard = s.root[0];
         r.sticky = (s.rem != 28'h0);
      end
      return r;
   endfunction

   // Truncating add; b carries its effective sign, flipped by the caller for
   // subtraction, so one saturation rule covers add and subtract halves
   function automatic vfss_elem_s fadd(
      input logic [31:0] a,
      input logic [31:0] b,
      input vfss_rnd_e rnd
   );
      vfss_elem_s r;
      logic [31:0] p;
      logic [31:0] q;
      logic [23:0] mp;
      logic [23:0] mq;
      logic [7:0] d;
      logic [72:0] w;
      logic [48:0] t;
      logic [48:0] s;
      logic [48:0] sn;
      logic [5:0] lz;
      logic [9:0] e;
      logic [31:0] zero;
      r = '0;
      zero = (rnd == VFSS_ROUND_TOWARD_MINUS_INFINITY) ? VFSS_NEG_ZERO : VFSS_POS_ZERO;
      if (a[30:0] >= b[30:0]) begin
         p = a;
         q = b;
      end else begin
         p = b;
         q = a;
      end
      // Denormals count as zero in the datapath
      mp = (p[30:23] == 8'h00) ? 24'h0 : {1'b1, p[22:0]};
      mq = (q[30:23] == 8'h00) ? 24'h0 : {1'b1, q[22:0]};
      d = p[30:23] - q[30:23];
      // Capped shift keeps the lead bit in the sticky tail; up to two low bits shift out
      w = {1'b0, mq, 48'h0} >> ((d > VFSS_SHIFT_CAP) ? VFSS_SHIFT_CAP : d);
      t = {w[72:25], |w[24:0]};
      if (p[31] == q[31]) begin
         s = {1'b0, mp, 24'h0} + t;
      end else begin
         s = {1'b0, mp, 24'h0} - t;
      end
      lz = 6'h31;
      for (int i = 0; i < 49; i++) begin
         if (s[i]) begin
            lz = 6'(48 - i);
         end
      end
      sn = s << lz;
      e = {2'b00, p[30:23]} + 10'h001 - {4'h0, lz};
      r.inv = is_bad(a) || is_bad(b);
      if (a[30:23] == VFSS_EXP_MAX) begin
         r.res = a[31] ? VFSS_NMAX : VFSS_PMAX;
      end else if (b[30:23] == VFSS_EXP_MAX) begin
         r.res = b[31] ? VFSS_NMAX : VFSS_PMAX;
      end else if (s == 49'h0) begin
         r.res = zero;
      end else if (!e[9] && (e[8] || e[7:0] == VFSS_EXP_MAX)) begin
         r.res = p[31] ? VFSS_NMAX : VFSS_PMAX;
         r.ovf = 1'b1;
      end else if (e[9] || e == 10'h000) begin
         r.res = zero;
         r.unf = 1'b1;
      end else begin
         r.res = {p[31], e[7:0], sn[47:25]};
         r.guard = sn[24];
         r.sticky = |sn[23:0];
      end
      return r;
   endfunction

   // ----------------------------------------------------------------
   // Reset release
   // ----------------------------------------------------------------
   logic [1:0] rst_sync_reg;
   logic rst_int_b;

   // Two flops so release never lands near an edge
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         rst_sync_reg <= VFSS_RST_SYNC_RESET;
      end else begin
         rst_sync_reg <= {rst_sync_reg[0], 1'b1};
      end
   end
   assign rst_int_b = rst_sync_reg[1];

   // ----------------------------------------------------------------
   // Operation control
   // ----------------------------------------------------------------
   vfss_state_s st_reg;
   vfss_state_s st_next;
   vfss_elem_s eh;
   vfss_elem_s el;
   logic any_inv;
   logic any_ovf;
   logic any_unf;
   logic inexact;
   logic trap_main;
   logic set_low;
   logic set_high;

   // Operand routing per operation; high element is bits 63:32
   always_comb begin
      case (st_reg.op)
         VFSS_OP_SQRT: begin
            eh = root_fin(st_reg.a[63:32], st_reg.rh);
            el = root_fin(st_reg.a[31:0], st_reg.rl);
         end
         VFSS_OP_SUB, VFSS_OP_SUBADD: begin
            eh = fadd(st_reg.a[63:32], st_reg.b[63:32] ^ VFSS_NEG_ZERO, st_reg.rnd);
            el = fadd(st_reg.a[31:0], st_reg.b[31:0] ^ VFSS_NEG_ZERO, st_reg.rnd);
         end
         VFSS_OP_SUBADDX: begin
            eh = fadd(st_reg.a[31:0], st_reg.b[63:32] ^ VFSS_NEG_ZERO, st_reg.rnd);
            el = fadd(st_reg.a[63:32], st_reg.b[31:0], st_reg.rnd);
         end
         default: begin
            eh = fadd(st_reg.a[31:0], st_reg.b[63:32] ^ VFSS_NEG_ZERO, st_reg.rnd);
            el = fadd(st_reg.a[63:32], st_reg.b[31:0] ^ VFSS_NEG_ZERO, st_reg.rnd);
         end
      endcase
   end

   // Trap priority: invalid, then overflow/underflow, then inexact
   always_comb begin
      any_inv = eh.inv || el.inv;
      any_ovf = !any_inv && (eh.ovf || el.ovf);
      any_unf = !any_inv && (eh.unf || el.unf);
      if (any_inv) begin
         trap_main = st_reg.en.invalid;
      end else begin
         trap_main = (any_ovf && st_reg.en.overflow) || (any_unf && st_reg.en.underflow);
      end
      inexact = !any_inv && (eh.guard || eh.sticky || el.guard || el.sticky
         || (any_ovf && !st_reg.en.overflow) || (any_unf && !st_reg.en.underflow));
      set_low = !trap_main && inexact;
      set_high = set_low && (st_reg.op == VFSS_OP_SQRT);
   end

   // Sequencer and result register
   always_comb begin
      st_next = st_reg;
      st_next.done = 1'b0;
      st_next.dest_we = 1'b0;
      st_next.irq_data = 1'b0;
      st_next.irq_round = 1'b0;
      // Set beats clear when both land together
      st_next.inexact_sticky_low = (st_reg.inexact_sticky_low && !sticky_clear) || 1'b0;
      st_next.inexact_sticky_high = st_reg.inexact_sticky_high && !sticky_clear;
      case (st_reg.fsm)
         VFSS_IDLE: begin
            if (op_valid) begin
               st_next.op = op_code;
               st_next.rnd = round_mode;
               st_next.en = exc_enable;
               st_next.a = src_a;
               st_next.b = src_b;
               st_next.busy = 1'b1;
               st_next.step = 5'h00;
               st_next.rh = root_load(src_a[63:32]);
               st_next.rl = root_load(src_a[31:0]);
               st_next.fsm = (op_code == VFSS_OP_SQRT) ? VFSS_ROOT : VFSS_FINISH;
            end
         end
         VFSS_ROOT: begin
            // Both halves iterate side by side, one root bit per cycle
            st_next.rh = root_step(st_reg.rh);
            st_next.rl = root_step(st_reg.rl);
            st_next.step = st_reg.step + 5'h01;
            if (st_reg.step == VFSS_SQRT_STEPS - 5'h01) begin
               st_next.fsm = VFSS_FINISH;
            end
         end
         VFSS_FINISH: begin
            st_next.fsm = VFSS_IDLE;
            st_next.busy = 1'b0;
            st_next.done = 1'b1;
            st_next.dest_we = !trap_main;
            if (!trap_main) begin
               st_next.dest = {eh.res, el.res};
            end
            st_next.irq_data = trap_main;
            st_next.irq_round = set_low && st_reg.en.inexact;
            st_next.flags.invalid_flag_high = eh.inv;
            st_next.flags.invalid_flag_low = el.inv;
            st_next.flags.overflow_flag_high = !any_inv && eh.ovf;
            st_next.flags.overflow_flag_low = !any_inv && el.ovf;
            st_next.flags.underflow_flag_high = !any_inv && eh.unf;
            st_next.flags.underflow_flag_low = !any_inv && el.unf;
            // Guard and sticky let a round handler finish truncated results
            st_next.flags.guard_bit_high = !any_inv && eh.guard;
            st_next.flags.guard_bit_low = !any_inv && el.guard;
            st_next.flags.sticky_bit_high = !any_inv && eh.sticky;
            st_next.flags.sticky_bit_low = !any_inv && el.sticky;
            st_next.inexact_sticky_low = st_next.inexact_sticky_low || set_low;
            st_next.inexact_sticky_high = st_next.inexact_sticky_high || set_high;
         end
         default: begin
            st_next.fsm = VFSS_IDLE;
            st_next.busy = 1'b0;
         end
      endcase
   end

   // Single state register
   always_ff @(posedge clk or negedge rst_int_b) begin
      if (!rst_int_b) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   // ----------------------------------------------------------------
   // Outputs, all from the state register
   // ----------------------------------------------------------------
   assign busy = st_reg.busy;
   assign done = st_reg.done;
   assign dest_we = st_reg.dest_we;
   assign dest_reg = st_reg.dest;
   assign flags = st_reg.flags;
   assign inexact_sticky_low = st_reg.inexact_sticky_low;
   assign inexact_sticky_high = st_reg.inexact_sticky_high;
   assign irq_data = st_reg.irq_data;
   assign irq_round = st_reg.irq_round;

endmodule

// ==== test/vfss_issue_model.sv ====
// Issue-side model: presents one request and holds it until the unit takes it.
// Assumes the bench pulses go for one cycle with the operands alongside.
`timescale 1ns/1ps

module vfss_issue_model
   import vfss_pkg::*;
(
   input wire logic clk,
   input wire logic rst_b,
   input wire logic busy,
   input wire logic go,
   input wire vfss_op_e op,
   input wire logic [63:0] a,
   input wire logic [63:0] b,
   output logic op_valid,
   output vfss_op_e op_code,
   output logic [63:0] src_a,
   output logic [63:0] src_b
);
   // Held until taken; operands scrambled once taken, so that stale reads fail
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         op_valid <= 1'b0;
         op_code <= VFSS_OP_SUB;
         src_a <= 64'h0;
         src_b <= 64'h0;
      end else if (go) begin
         op_valid <= 1'b1;
         op_code <= op;
         src_a <= a;
         src_b <= b;
      end else if (op_valid && !busy) begin
         op_valid <= 1'b0;
         src_a <= ~src_a;
         src_b <= ~src_b;
      end
   end
endmodule

// ==== test/vfss_unit_props.sv ====
// Checker on the unit's ports: latency, writes, traps and sticky bits.
// Assumes one clock and the unit's active-low reset.
`timescale 1ns/1ps

module vfss_unit_chk
   import vfss_pkg::*;
(
   input wire logic clk,
   input wire logic rst_b,
   input wire logic op_valid,
   input wire vfss_op_e op_code,
   input wire logic sticky_clear,
   input wire logic busy,
   input wire logic done,
   input wire logic dest_we,
   input wire logic [63:0] dest_reg,
   input wire vfss_flags_s flags,
   input wire logic inexact_sticky_low,
   input wire logic inexact_sticky_high,
   input wire logic irq_data,
   input wire logic irq_round
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_b);
   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   logic take;
   logic inv;
   assign take = op_valid && !busy;
   assign inv = flags.invalid_flag_high || flags.invalid_flag_low;

   property p_sub_lat;
      take && op_code != VFSS_OP_SQRT |=> busy ##1 (done && !busy);
   endproperty
   a_sub_lat: assert property (p_sub_lat) else $error("subtract latency");
   property p_sqrt_lat;
      take && op_code == VFSS_OP_SQRT |-> ##27 (done && !busy);
   endproperty
   a_sqrt_lat: assert property (p_sqrt_lat) else $error("root latency");
   property p_we_done;
      dest_we |-> done && !irq_data;
   endproperty
   a_we_done: assert property (p_we_done) else $error("write with trap");
   property p_one_irq;
      irq_data || irq_round |-> done && !(irq_data && irq_round);
   endproperty
   a_one_irq: assert property (p_one_irq) else $error("two traps");
   property p_dest_hold;
      $changed(dest_reg) |-> dest_we;
   endproperty
   a_dest_hold: assert property (p_dest_hold) else $error("dest moved");
   property p_inv_clean;
      done && inv |-> flags[7:0] == 8'h00 && !irq_round;
   endproperty
   a_inv_clean: assert property (p_inv_clean) else $error("invalid flags");
   property p_sticky_keep;
      $fell(inexact_sticky_low) || $fell(inexact_sticky_high) |-> $past(sticky_clear);
   endproperty
   a_sticky_keep: assert property (p_sticky_keep) else $error("sticky lost");
   property p_round_sets;
      irq_round |-> dest_we && inexact_sticky_low;
   endproperty
   a_round_sets: assert property (p_round_sets) else $error("round trap");
   // Main scenarios reached
   c_sqrt: cover property (take && op_code == VFSS_OP_SQRT);
   c_trap: cover property (irq_data);
   c_round: cover property (irq_round);
endmodule

bind vfss_unit vfss_unit_chk i_chk (.clk, .rst_b, .op_valid, .op_code, .sticky_clear,
   .busy, .done, .dest_we, .dest_reg, .flags, .inexact_sticky_low, .inexact_sticky_high,
   .irq_data, .irq_round);

// ==== test/tb.sv ====
// Directed bench for the paired subtract and root unit.
// Assumes the issue model feeds requests; results are judged at done.
`timescale 1ns/1ps

module tb import vfss_pkg::*; ;
   localparam vfss_op_e SQ = VFSS_OP_SQRT;
   localparam vfss_op_e SB = VFSS_OP_SUB;
   logic clk, rst_b, go, sticky_clear, op_valid, busy, done, dest_we, irq_data, irq_round;
   logic inexact_sticky_low, inexact_sticky_high;
   logic [63:0] a_r, b_r, src_a, src_b, dest_reg, last;
   vfss_op_e op_r, op_code;
   vfss_rnd_e rnd;
   vfss_en_s en;
   vfss_flags_s flags;
   int fails, compares;

   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   vfss_issue_model i_iss (.clk(clk), .rst_b(rst_b), .busy(busy), .go(go), .op(op_r),
      .a(a_r), .b(b_r), .op_valid(op_valid), .op_code(op_code), .src_a(src_a), .src_b(src_b));
   vfss_unit i_dut (.clk(clk), .rst_b(rst_b), .op_valid(op_valid), .op_code(op_code),
      .src_a(src_a), .src_b(src_b), .round_mode(rnd), .exc_enable(en),
      .sticky_clear(sticky_clear), .busy(busy), .done(done), .dest_we(dest_we),
      .dest_reg(dest_reg), .flags(flags), .inexact_sticky_low(inexact_sticky_low),
      .inexact_sticky_high(inexact_sticky_high), .irq_data(irq_data), .irq_round(irq_round));

   // ----------------------------------------------------------------
   // Shared tasks
   // ----------------------------------------------------------------
   task automatic chk(input logic c, input string m);
      compares++;
      if (!c) begin
         fails++;
         $display("BAD %0t %s", $time, m);
      end
   endtask

   // Enables and rounding change only between operations; stickies cleared
   task automatic setup(input logic [3:0] e, input vfss_rnd_e r = VFSS_ROUND_TO_NEAREST);
      @(posedge clk);
      en <= vfss_en_s'(e);
      rnd <= r;
      sticky_clear <= 1'b1;
      @(posedge clk);
      sticky_clear <= 1'b0;
   endtask

   // ev is {dest_we, irq_data, irq_round}; a clear dest_we bit expects the old destination
   task automatic run(input vfss_op_e op, input logic [63:0] a, input logic [63:0] b,
      input logic [63:0] ed, input logic [2:0] ev, input logic [9:0] ef = 10'h0,
      input logic [9:0] fm = 10'h3f0);
      int n;
      @(posedge clk);
      go <= 1'b1;
      op_r <= op;
      a_r <= a;
      b_r <= b;
      @(posedge clk);
      go <= 1'b0;
      n = 0;
      do begin
         @(negedge clk);
         n++;
      end while (done !== 1'b1 && n < 60);
      if (!ev[2]) ed = last;
      chk(done === 1'b1, "no done");
      chk(dest_reg === ed, "dest value");
      chk({dest_we, irq_data, irq_round} === ev, "write or trap");
      chk((flags & fm) === (ef & fm), "flags");
      last = ed;
   endtask

   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   task automatic t_sqrt;
      setup(4'h2);
      run(SQ, 64'h00800000_3f800000, 64'h0, 64'h20000000_3f800000, 3'h4, 10'h0, 10'h3ff);
      run(SQ, 64'h40800000_41100000, 64'h0, 64'h40000000_40400000, 3'h4, 10'h0, 10'h3ff);
      chk(inexact_sticky_high === 1'b0, "exact root sticky");
      run(SQ, 64'h7f800000_bf800000, 64'h0, {VFSS_PMAX, VFSS_NEG_ZERO}, 3'h4, 10'h300);
      run(SQ, 64'h80000000_00000001, 64'h0, 64'h80000000_00000000, 3'h4, 10'h100);
      run(SQ, 64'h40000000_40800000, 64'h0, 64'h3fb504f3_40000000, 3'h4);
      chk({inexact_sticky_high, inexact_sticky_low} === 2'h3, "root stickies");
   endtask

   task automatic t_sub;
      setup(4'h0);
      run(SB, 64'h40400000_3f800000, 64'h3f800000_40400000, 64'h40000000_c0000000, 3'h4);
      chk(inexact_sticky_low === 1'b0, "exact sub sticky");
      run(SB, 64'hff800000_3f800000, 64'h7f800000_ffc00000, {VFSS_NMAX, VFSS_PMAX}, 3'h4,
         10'h300, 10'h3ff);
      run(SB, 64'h7f7fffff_ff7fffff, 64'hff7fffff_7f7fffff, {VFSS_PMAX, VFSS_NMAX}, 3'h4,
         10'h0c0);
      chk(inexact_sticky_low === 1'b1, "overflow sticky");
      setup(4'h4);
      run(SB, 64'h7f7fffff_3f800000, 64'hff7fffff_3f800000, 64'h0, 3'h2, 10'h080);
   endtask

   task automatic t_unf;
      logic [31:0] z;
      for (int r = 0; r < 4; r++) begin
         setup(4'h0, vfss_rnd_e'(r));
         z = (r == 3) ? VFSS_NEG_ZERO : VFSS_POS_ZERO;
         run(SB, 64'h00800001_00800001, 64'h00800000_00800000, {z, z}, 3'h4, 10'h030);
      end
      setup(4'h2);
      run(SB, 64'h00800001_3f800000, 64'h00800000_3f800000, 64'h0, 3'h2, 10'h020);
   endtask

   task automatic t_pair;
      setup(4'h0);
      run(VFSS_OP_SUBADD, 64'h40a00000_40000000, 64'h3f800000_3f000000,
         64'h40800000_3fc00000, 3'h4);
      run(VFSS_OP_SUBADDX, 64'h3f800000_40800000, 64'h40000000_40400000,
         64'h40000000_40800000, 3'h4);
      run(VFSS_OP_SUBX, 64'h3f800000_40800000, 64'h40000000_40400000,
         64'h40000000_c0000000, 3'h4);
      run(VFSS_OP_SUBX, 64'h3f800000_ff800000, 64'hff800000_7f800000,
         {VFSS_NMAX, VFSS_NMAX}, 3'h4, 10'h300);
   endtask

   task automatic t_trap;
      setup(4'h8);
      run(SB, 64'h7fc00000_3f800000, 64'h0, 64'h0, 3'h2, 10'h200);
      run(SQ, 64'hbf800000_40800000, 64'h0, 64'h0, 3'h2, 10'h200);
      setup(4'h1);
      run(SB, 64'h3f800000_40000000, 64'h30800000_30800000, 64'h3f7fffff_3fffffff, 3'h5,
         10'h00f, 10'h3ff);
      chk((flags.guard_bit_low && flags.sticky_bit_low) === 1'b1, "guard bits");
   endtask

   // ----------------------------------------------------------------
   // Verdict, main sequence and watchdog
   // ----------------------------------------------------------------
   task automatic results;
      $display("compares %0d fails %0d", compares, fails);
      if (fails == 0 && compares > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   initial begin
      rst_b = 1'b0;
      go = 1'b0;
      sticky_clear = 1'b0;
      op_r = SB;
      a_r = 64'h0;
      b_r = 64'h0;
      rnd = VFSS_ROUND_TO_NEAREST;
      en = 4'h0;
      last = 64'h0;
      repeat (16) @(posedge clk);
      rst_b <= 1'b1;
      repeat (4) @(posedge clk);
      t_sqrt;
      t_sub;
      t_unf;
      t_pair;
      t_trap;
      results;
   end

   // About 20 operations of at most 35 cycles each; generous margin
   initial begin
      repeat (5000) @(posedge clk);
      fails++;
      results;
   end
endmodule
